// *** logic/pbcs_regs.svh ***
// Register indices, bit positions, codes and frame counts of the basic PHY register pair.
`ifndef PBCS_REGS_SVH
`define PBCS_REGS_SVH

// Register indices and the broadcast PHY address on the management interface.
`define PBCS_IDX_CONTROL 5'h00
`define PBCS_IDX_STATUS 5'h01
`define PBCS_ADDR_ANY 5'h00

// basic_phy_control bit positions.
`define PBCS_CTL_RESET 15
`define PBCS_CTL_LOOPBACK 14
`define PBCS_CTL_SPEED_LSB 13
`define PBCS_CTL_NEG_ENABLE 12
`define PBCS_CTL_POWER_DOWN 11
`define PBCS_CTL_ISOLATE 10
`define PBCS_CTL_NEG_RESTART 9
`define PBCS_CTL_DUPLEX 8
`define PBCS_CTL_COL_TEST 7
`define PBCS_CTL_SPEED_MSB 6
`define PBCS_CTL_ONE_WAY 5

// basic_phy_status bit positions.
`define PBCS_STS_EXT_STATUS 8
`define PBCS_STS_ONE_WAY_ABILITY 7
`define PBCS_STS_SHORT_PREAMBLE 6
`define PBCS_STS_NEG_COMPLETE 5
`define PBCS_STS_REMOTE_FAULT 4

// Codes and fixed values.
`define PBCS_SPEED_100 2'h1
`define PBCS_PMODE_NORMAL 4'h3
`define PBCS_OP_READ 2'h2
`define PBCS_OP_WRITE 2'h1
`define PBCS_WORD_ZERO 16'h0000

// Frame field lengths, as last-bit counts.
`define PBCS_HDR_LAST 5'h0B
`define PBCS_TA_LAST 5'h01
`define PBCS_DATA_LAST 5'h0F

`endif

// *** logic/pbcs_pkg.sv ***
// Types shared by the basic PHY register pair.
package pbcs_pkg;

   typedef enum logic [2:0] {
      SMI_IDLE,
      SMI_HEADER,
      SMI_TURN,
      SMI_READ,
      SMI_WRITE
   } pbcs_state_t;

   typedef struct packed {
      logic loopback;
      logic power_down;
      logic isolate;
      logic one_way_tx_enable;
   } pbcs_ctrl_t;

   typedef struct packed {
      logic [1:0] op;
      logic [4:0] phy;
      logic [4:0] idx;
   } pbcs_hdr_t;

endpackage

// *** logic/pbcs_sync.sv ***
// Three-stage synchroniser that passes a level once its last two stages agree.
`timescale 1ns/10ps
module pbcs_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Asynchronous level in, filtered level out
   input wire logic async_in,
   output logic level_out
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic out_reg;
   logic out_next;

   always_comb begin
      out_next = out_reg;
      if (s2_reg == s3_reg) begin
         out_next = s3_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
         out_reg <= RESET_VAL;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign level_out = out_reg;

endmodule

// *** logic/pbcs_top.sv ***
// Basic PHY control and status register pair behind a serial management slave.
`timescale 1ns/10ps
`include "pbcs_regs.svh"
module pbcs_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Management link pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n,
   // Strap and PHY core status
   input wire logic [4:0] phy_addr_strap,
   input wire logic [3:0] power_mode_sel,
   input wire logic [1:0] loopback_variant,
   input wire logic link_up,
   input wire logic remote_fault_det,
   // PHY core controls
   output logic phy_soft_reset,
   output logic loopback_enable,
   output logic [1:0] loopback_select,
   output logic standby_request,
   output logic isolate_mii,
   output logic one_way_tx_enable,
   output logic mii_tx_allowed,
   output logic normal_mode_request,
   output logic control_error
);

   logic mdc_lvl;
   logic mdio_lvl;

   pbcs_sync #(
      .RESET_VAL(1'b0)
   ) u_sync_mdc (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(mdc),
      .level_out(mdc_lvl)
   );

   pbcs_sync #(
      .RESET_VAL(1'b1)
   ) u_sync_mdio (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(mdio_in),
      .level_out(mdio_lvl)
   );

   pbcs_pkg::pbcs_state_t state_reg, state_next;
   pbcs_pkg::pbcs_ctrl_t ctrl_reg, ctrl_next;
   pbcs_pkg::pbcs_hdr_t hdr_reg, hdr_next;
   logic mdc_prev_reg, mdc_prev_next;
   logic bit_prev_reg, bit_prev_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [15:0] shift_reg, shift_next;
   logic read_act_reg, read_act_next;
   logic commit_reg, commit_next;
   logic mdio_out_reg, mdio_out_next;
   logic mdio_oe_n_reg, mdio_oe_n_next;
   logic [4:0] phy_addr_reg, phy_addr_next;
   logic rf_reg, rf_next;
   logic soft_rst_reg, soft_rst_next;
   logic normal_req_reg, normal_req_next;
   logic ctl_err_reg, ctl_err_next;
   logic tx_allowed_reg, tx_allowed_next;
   logic [1:0] lb_sel_reg, lb_sel_next;

   logic mdc_rise;
   logic [15:0] ctl_word;
   logic [15:0] sts_word;
   pbcs_pkg::pbcs_hdr_t hdr_now;
   logic [15:0] wr_word;
   logic addr_hit;

   assign mdc_rise = mdc_lvl & ~mdc_prev_reg;
   assign hdr_now = pbcs_pkg::pbcs_hdr_t'({shift_reg[10:0], mdio_lvl});
   assign wr_word = {shift_reg[14:0], mdio_lvl};
   assign addr_hit = (hdr_now.phy == phy_addr_reg) || (hdr_now.phy == `PBCS_ADDR_ANY);

   // Read-back images; fixed bits are built here rather than stored.
   always_comb begin
      ctl_word = `PBCS_WORD_ZERO;
      ctl_word[`PBCS_CTL_LOOPBACK] = ctrl_reg.loopback;
      {ctl_word[`PBCS_CTL_SPEED_MSB], ctl_word[`PBCS_CTL_SPEED_LSB]} = `PBCS_SPEED_100;
      ctl_word[`PBCS_CTL_NEG_ENABLE] = 1'b0;
      ctl_word[`PBCS_CTL_NEG_RESTART] = 1'b0;
      ctl_word[`PBCS_CTL_POWER_DOWN] = ctrl_reg.power_down;
      ctl_word[`PBCS_CTL_ISOLATE] = ctrl_reg.isolate;
      ctl_word[`PBCS_CTL_DUPLEX] = 1'b1;
      ctl_word[`PBCS_CTL_COL_TEST] = 1'b0;
      ctl_word[`PBCS_CTL_ONE_WAY] = ctrl_reg.one_way_tx_enable;
      ctl_word[`PBCS_CTL_RESET] = 1'b0;

      sts_word = `PBCS_WORD_ZERO;
      sts_word[`PBCS_STS_EXT_STATUS] = 1'b1;
      sts_word[`PBCS_STS_ONE_WAY_ABILITY] = 1'b1;
      sts_word[`PBCS_STS_SHORT_PREAMBLE] = 1'b1;
      sts_word[`PBCS_STS_NEG_COMPLETE] = 1'b1;
      sts_word[`PBCS_STS_REMOTE_FAULT] = rf_reg;
   end

   always_comb begin
      state_next = state_reg;
      ctrl_next = ctrl_reg;
      hdr_next = hdr_reg;
      mdc_prev_next = mdc_lvl;
      bit_prev_next = bit_prev_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      read_act_next = read_act_reg;
      commit_next = commit_reg;
      mdio_out_next = mdio_out_reg;
      mdio_oe_n_next = mdio_oe_n_reg;
      phy_addr_next = phy_addr_reg;
      rf_next = rf_reg;
      soft_rst_next = 1'b0;
      normal_req_next = 1'b0;
      ctl_err_next = 1'b0;
      tx_allowed_next = ctrl_reg.one_way_tx_enable | link_up;
      lb_sel_next = ctrl_reg.loopback ? loopback_variant : lb_sel_reg;

      if (mdc_rise) begin
         case (state_reg)
            pbcs_pkg::SMI_IDLE: begin
               bit_prev_next = mdio_lvl;
               // start pattern alone opens a frame, preamble optional
               if (!bit_prev_reg && mdio_lvl) begin
                  state_next = pbcs_pkg::SMI_HEADER;
                  cnt_next = 5'h00;
               end
            end
            pbcs_pkg::SMI_HEADER: begin
               shift_next = wr_word;
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == `PBCS_HDR_LAST) begin
                  hdr_next = hdr_now;
                  state_next = pbcs_pkg::SMI_TURN;
                  cnt_next = 5'h00;
                  read_act_next = addr_hit && (hdr_now.op == `PBCS_OP_READ);
                  commit_next = addr_hit && (hdr_now.op == `PBCS_OP_WRITE);
                  if (hdr_now.idx == `PBCS_IDX_CONTROL) begin
                     shift_next = ctl_word;
                  end else if (hdr_now.idx == `PBCS_IDX_STATUS) begin
                     shift_next = sts_word;
                  end else begin
                     shift_next = `PBCS_WORD_ZERO;
                  end
                  // clear latched fault on status read
                  if (addr_hit && (hdr_now.op == `PBCS_OP_READ) &&
                      (hdr_now.idx == `PBCS_IDX_STATUS)) begin
                     rf_next = 1'b0;
                  end
               end
            end
            pbcs_pkg::SMI_TURN: begin
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == `PBCS_TA_LAST) begin
                  cnt_next = 5'h00;
                  if (read_act_reg) begin
                     state_next = pbcs_pkg::SMI_READ;
                     mdio_out_next = shift_reg[15];
                     shift_next = {shift_reg[14:0], 1'b0};
                  end else begin
                     state_next = pbcs_pkg::SMI_WRITE;
                  end
               end else if (read_act_reg) begin
                  mdio_out_next = 1'b0;
                  mdio_oe_n_next = 1'b0;
               end
            end
            pbcs_pkg::SMI_READ: begin
               cnt_next = cnt_reg + 5'h01;
               mdio_out_next = shift_reg[15];
               shift_next = {shift_reg[14:0], 1'b0};
               if (cnt_reg == `PBCS_DATA_LAST) begin
                  mdio_out_next = 1'b1;
                  mdio_oe_n_next = 1'b1;
                  state_next = pbcs_pkg::SMI_IDLE;
                  bit_prev_next = 1'b1;
               end
            end
            pbcs_pkg::SMI_WRITE: begin
               cnt_next = cnt_reg + 5'h01;
               shift_next = wr_word;
               if (cnt_reg == `PBCS_DATA_LAST) begin
                  state_next = pbcs_pkg::SMI_IDLE;
                  bit_prev_next = 1'b1;
                  if (commit_reg && (hdr_reg.idx == `PBCS_IDX_CONTROL)) begin
                     if (wr_word[`PBCS_CTL_RESET]) begin
                        soft_rst_next = 1'b1;
                     end else begin
                        ctrl_next.loopback = wr_word[`PBCS_CTL_LOOPBACK];
                        ctrl_next.one_way_tx_enable = wr_word[`PBCS_CTL_ONE_WAY];
                        ctrl_next.power_down = wr_word[`PBCS_CTL_POWER_DOWN] &
                           ~ctrl_reg.isolate &
                           ~(wr_word[`PBCS_CTL_ISOLATE] & ~ctrl_reg.power_down);
                        ctrl_next.isolate = wr_word[`PBCS_CTL_ISOLATE] &
                           ~ctrl_reg.power_down &
                           ~(wr_word[`PBCS_CTL_POWER_DOWN] & ~ctrl_reg.isolate);
                        ctl_err_next =
                           (wr_word[`PBCS_CTL_POWER_DOWN] & ~ctrl_next.power_down) |
                           (wr_word[`PBCS_CTL_ISOLATE] & ~ctrl_next.isolate);
                        normal_req_next = ctrl_reg.power_down & ~ctrl_next.power_down &
                           ~wr_word[`PBCS_CTL_POWER_DOWN] &
                           (power_mode_sel == `PBCS_PMODE_NORMAL);
                     end
                  end
               end
            end
            default: begin
               state_next = pbcs_pkg::SMI_IDLE;
            end
         endcase
      end

      if (soft_rst_reg) begin
         ctrl_next = '0;
         rf_next = 1'b0;
      end
      // fault sets, winning over any clear
      if (remote_fault_det) begin
         rf_next = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg <= pbcs_pkg::SMI_IDLE;
         ctrl_reg <= '0;
         hdr_reg <= '0;
         mdc_prev_reg <= 1'b0;
         bit_prev_reg <= 1'b1;
         cnt_reg <= 5'h00;
         shift_reg <= `PBCS_WORD_ZERO;
         read_act_reg <= 1'b0;
         commit_reg <= 1'b0;
         mdio_out_reg <= 1'b1;
         mdio_oe_n_reg <= 1'b1;
         phy_addr_reg <= phy_addr_strap;
         rf_reg <= 1'b0;
         soft_rst_reg <= 1'b0;
         normal_req_reg <= 1'b0;
         ctl_err_reg <= 1'b0;
         tx_allowed_reg <= 1'b0;
         lb_sel_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         hdr_reg <= hdr_next;
         mdc_prev_reg <= mdc_prev_next;
         bit_prev_reg <= bit_prev_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         read_act_reg <= read_act_next;
         commit_reg <= commit_next;
         mdio_out_reg <= mdio_out_next;
         mdio_oe_n_reg <= mdio_oe_n_next;
         phy_addr_reg <= phy_addr_next;
         rf_reg <= rf_next;
         soft_rst_reg <= soft_rst_next;
         normal_req_reg <= normal_req_next;
         ctl_err_reg <= ctl_err_next;
         tx_allowed_reg <= tx_allowed_next;
         lb_sel_reg <= lb_sel_next;
      end
   end

   assign mdio_out = mdio_out_reg;
   assign mdio_oe_n = mdio_oe_n_reg;
   assign phy_soft_reset = soft_rst_reg;
   assign loopback_enable = ctrl_reg.loopback;
   assign loopback_select = lb_sel_reg;
   assign standby_request = ctrl_reg.power_down;
   assign isolate_mii = ctrl_reg.isolate;
   assign one_way_tx_enable = ctrl_reg.one_way_tx_enable;
   assign mii_tx_allowed = tx_allowed_reg;
   assign normal_mode_request = normal_req_reg;
   assign control_error = ctl_err_reg;

endmodule

// *** testbench/pbcs_properties.sv ***
// Port-level checks of the basic PHY register pair.
`timescale 1ns/10ps
`include "pbcs_regs.svh"
module pbcs_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Levels from the PHY core
   input wire logic [3:0] power_mode_sel,
   input wire logic [1:0] loopback_variant,
   input wire logic link_up,
   // Controls towards the PHY core
   input wire logic phy_soft_reset,
   input wire logic loopback_enable,
   input wire logic [1:0] loopback_select,
   input wire logic standby_request,
   input wire logic isolate_mii,
   input wire logic one_way_tx_enable,
   input wire logic mii_tx_allowed,
   input wire logic normal_mode_request,
   input wire logic control_error
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   AST_SOFT_RESET_CLEARS: assert property (
      phy_soft_reset |-> ##[0:1] !(loopback_enable || standby_request || isolate_mii
         || one_way_tx_enable)) else $error("soft reset left a control set");
   AST_SOFT_RESET_PULSE: assert property (
      phy_soft_reset |=> !phy_soft_reset) else $error("soft reset pulse too long");
   AST_POWER_ISOLATE_EXCLUSIVE: assert property (
      !(standby_request && isolate_mii)) else $error("standby and isolation both set");
   AST_STANDBY_RISE_CLEAN: assert property (
      $rose(standby_request) |-> !isolate_mii && !control_error)
      else $error("standby entered while refused");
   AST_ERROR_KEEPS_STATE: assert property (
      control_error |-> !$rose(standby_request) && !$rose(isolate_mii))
      else $error("refused request still applied");
   AST_TX_GATE: assert property (
      !$past(sys_rst) |-> mii_tx_allowed == $past(one_way_tx_enable || link_up))
      else $error("transmit gate wrong");
   AST_NORMAL_REQUEST: assert property (
      normal_mode_request |-> !standby_request && power_mode_sel == `PBCS_PMODE_NORMAL)
      else $error("normal request without cause");
   AST_LOOP_COPY: assert property (
      loopback_enable && $past(loopback_enable) |-> loopback_select == $past(loopback_variant))
      else $error("loopback variant not followed");
   AST_LOOP_HOLD: assert property (
      !loopback_enable && !$past(loopback_enable) |-> $stable(loopback_select))
      else $error("loopback variant moved while off");
endmodule

// *** testbench/pbcs_host.sv ***
// Station management host model that frames reads and writes on the link.
`timescale 1ns/10ps
`include "pbcs_regs.svh"
module pbcs_host (
   // Link lines
   output logic mdc,
   output logic drv_en,
   output logic drv_val,
   input wire logic mdio_wire
);
   initial begin
      mdc = 1'b0;
      drv_en = 1'b0;
      drv_val = 1'b1;
   end

   // The clock stands low between frames. Data moves mid low phase, well clear of the rise,
   // because the device sees both lines only through its synchronisers.
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
         input logic [15:0] wd, output logic [15:0] rd);
      logic [31:0] bits;
      bits = {2'b01, op, pa, ra, 2'b10, wd[15:5], 5'h00};
      rd = 16'h0000;
      for (int i = 0; i < 32; i++) begin
         #50;
         drv_en = (op != `PBCS_OP_READ) || (i < 14);
         drv_val = bits[31 - i];
         #50;
         mdc = 1'b1;
         if (i >= 16) begin
            rd = {rd[14:0], mdio_wire};
         end
         #100;
         mdc = 1'b0;
      end
      drv_en = 1'b0;
      #400;
   endtask
endmodule

// *** testbench/pbcs_top_tb.sv ***
// Self-checking bench for the basic PHY register pair.
`timescale 1ns/10ps
`include "pbcs_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pbcs_top_tb;
   localparam logic [4:0] STRAP = 5'h05;
   localparam logic [15:0] CTL_DEF = 16'h2100;
   localparam logic [15:0] STS_DEF = 16'h01E0;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] power_mode_sel = 4'h0;
   logic [1:0] loopback_variant = 2'h1;
   logic link_up = 1'b0;
   logic remote_fault_det = 1'b0;
   logic mdc, drv_en, drv_val, mdio_out, mdio_oe_n, mdio_wire;
   logic phy_soft_reset, loopback_enable, standby_request, isolate_mii, one_way_tx_enable;
   logic mii_tx_allowed, normal_mode_request, control_error;
   logic [1:0] loopback_select;
   logic [15:0] rd;
   int error_cnt = 0;
   int checked = 0;
   int n_err = 0;
   int n_norm = 0;
   int n_rst = 0;

   // The line has a pull-up, so it reads high whenever neither end drives it.
   assign mdio_wire = (drv_en ? drv_val : 1'b1) & (mdio_oe_n ? 1'b1 : mdio_out);

   pbcs_host host (.mdc, .drv_en, .drv_val, .mdio_wire);
   pbcs_top uut (.core_clk, .sys_rst, .mdc, .mdio_in(mdio_wire), .mdio_out, .mdio_oe_n,
      .phy_addr_strap(STRAP), .power_mode_sel, .loopback_variant, .link_up, .remote_fault_det,
      .phy_soft_reset, .loopback_enable, .loopback_select, .standby_request, .isolate_mii,
      .one_way_tx_enable, .mii_tx_allowed, .normal_mode_request, .control_error);

   initial forever #12.5 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      if (!sys_rst && control_error === 1'b1) n_err++;
      if (!sys_rst && normal_mode_request === 1'b1) n_norm++;
      if (!sys_rst && phy_soft_reset === 1'b1) n_rst++;
   end

   task automatic tick;
      @(posedge core_clk);
      #2;
   endtask
   task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] dummy;
      host.xfer(`PBCS_OP_WRITE, pa, ra, d, dummy);
   endtask
   task automatic rdr(input logic [4:0] pa, input logic [4:0] ra);
      host.xfer(`PBCS_OP_READ, pa, ra, 16'h0000, rd);
   endtask

   task automatic t_defaults;
      rdr(STRAP, `PBCS_IDX_CONTROL);
      `CHK(rd, CTL_DEF)
      rdr(`PBCS_ADDR_ANY, `PBCS_IDX_STATUS);
      `CHK(rd, STS_DEF)
      `CHK({mdio_oe_n, mdio_out}, 2'h3)
      `CHK({loopback_enable, standby_request, isolate_mii, one_way_tx_enable}, 4'h0)
   endtask

   task automatic t_fixed_bits;
      logic [15:0] pat [4] = '{16'h1280, 16'h0040, 16'h2340, 16'h2000};
      foreach (pat[i]) begin
         wr(STRAP, `PBCS_IDX_CONTROL, pat[i]);
         rdr(STRAP, `PBCS_IDX_CONTROL);
         `CHK(rd, CTL_DEF)
      end
      wr(`PBCS_ADDR_ANY, `PBCS_IDX_STATUS, 16'hFFFF);
      rdr(STRAP, `PBCS_IDX_STATUS);
      `CHK(rd, STS_DEF)
      wr(5'h09, `PBCS_IDX_CONTROL, 16'h4000);
      rdr(5'h09, `PBCS_IDX_CONTROL);
      `CHK(rd, 16'hFFFF)
      rdr(STRAP, 5'h02);
      `CHK(rd, 16'h0000)
      `CHK(loopback_enable, 1'b0)
   endtask

   task automatic t_loop_oneway;
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h4020);
      rdr(STRAP, `PBCS_IDX_CONTROL);
      `CHK(rd, 16'h6120)
      `CHK({loopback_enable, loopback_select}, 3'h5)
      loopback_variant = 2'h2;
      tick();
      tick();
      `CHK(loopback_select, 2'h2)
      `CHK(mii_tx_allowed, 1'b1)
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h0000);
      `CHK(mii_tx_allowed, 1'b0)
      loopback_variant = 2'h3;
      tick();
      tick();
      `CHK(loopback_select, 2'h2)
      tick();
      link_up = 1'b1;
      tick();
      tick();
      `CHK(mii_tx_allowed, 1'b1)
      link_up = 1'b0;
   endtask

   task automatic t_power;
      power_mode_sel = `PBCS_PMODE_NORMAL;
      n_err = 0;
      n_norm = 0;
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h0800);
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h0C00);
      `CHK({standby_request, isolate_mii, n_err}, {2'b10, 32'd1})
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h0000);
      `CHK({standby_request, n_norm}, {1'b0, 32'd1})
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h0400);
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h0C00);
      `CHK({standby_request, isolate_mii, n_err}, {2'b01, 32'd2})
      rdr(STRAP, `PBCS_IDX_CONTROL);
      `CHK(rd, 16'h2500)
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h0000);
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h0C00);
      `CHK({standby_request, isolate_mii, n_err}, {2'b00, 32'd3})
      power_mode_sel = 4'h0;
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h0800);
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h0000);
      `CHK(n_norm, 1)
   endtask

   task automatic t_fault_reset;
      tick();
      remote_fault_det = 1'b1;
      tick();
      remote_fault_det = 1'b0;
      rdr(STRAP, `PBCS_IDX_STATUS);
      `CHK(rd, 16'h01F0)
      rdr(STRAP, `PBCS_IDX_STATUS);
      `CHK(rd, STS_DEF)
      remote_fault_det = 1'b1;
      rdr(STRAP, `PBCS_IDX_STATUS);
      remote_fault_det = 1'b0;
      `CHK(rd, 16'h01F0)
      rdr(STRAP, `PBCS_IDX_STATUS);
      `CHK(rd, 16'h01F0)
      rdr(STRAP, `PBCS_IDX_STATUS);
      `CHK(rd, STS_DEF)
      wr(STRAP, `PBCS_IDX_CONTROL, 16'h4820);
      tick();
      remote_fault_det = 1'b1;
      tick();
      remote_fault_det = 1'b0;
      n_rst = 0;
      wr(STRAP, `PBCS_IDX_CONTROL, 16'hC800);
      `CHK(n_rst, 1)
      `CHK({loopback_enable, standby_request, isolate_mii, one_way_tx_enable}, 4'h0)
      rdr(STRAP, `PBCS_IDX_CONTROL);
      `CHK(rd, CTL_DEF)
      rdr(STRAP, `PBCS_IDX_STATUS);
      `CHK(rd, STS_DEF)
   endtask

   task automatic summarize;
      if (error_cnt == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      #2 sys_rst = 1'b0;
      repeat (8) @(posedge core_clk);
      #2;
      t_defaults();
      t_fixed_bits();
      t_loop_oneway();
      t_power();
      t_fault_reset();
      summarize();
   end

   // A hang anywhere ends here, counted as a mismatch.
   initial begin
      repeat (100000) @(posedge core_clk);
      error_cnt++;
      summarize();
   end
endmodule

bind pbcs_top pbcs_properties chk (.core_clk, .sys_rst, .power_mode_sel, .loopback_variant,
   .link_up, .phy_soft_reset, .loopback_enable, .loopback_select, .standby_request,
   .isolate_mii, .one_way_tx_enable, .mii_tx_allowed, .normal_mode_request, .control_error);
